//--- dcmt_consts.vh
// Purpose: Constants for the dual channel modulo timer register block
// Assumes: AHB-Lite byte addresses are four times the register index
// Notes:   Every offset lives here; divider, toggle and channel interrupt enable bits and the halt reset value do not
//
// Summary of operation
// - Wait mode: timer runs, interrupt wakes CPU
// - Stop mode: timer frozen, state kept
// - Debug break halts the counter
// - Break, clear disabled: flags untouched by access
// - Break, clear enabled: cleared flag stays cleared
// - Overflow flag: set at period, read-then-zero clear
// - New overflow cancels pending zero write
// - Overflow enable gates interrupt; reset clears
// - Halt bit freezes counter; reset sets it
// - Clear bit zeroes counter, prescaler; reads zero
// - Halt plus clear stops counter at zero
// - Divider select: bus clock over two-power
// - High read latches low byte once
// - Break-time latch persists until low read
// - Match period sets flag, restarts from zero
// - Period high write suppresses overflow flag
// - Period registers reset to all ones
// - Channel control bit layout, reset zero
// - Channel pins capture or compare configurable
// - Channel flag read-then-zero clear, event wins
// - Overflow beats compare when toggle enabled
`ifndef DCMT_CONSTS_VH
`define DCMT_CONSTS_VH
// Register indices, byte address is index times four
`define DCMT_IDX_SC1    8'h20
`define DCMT_IDX_CNTH1  8'h21
`define DCMT_IDX_CNTL1  8'h22
`define DCMT_IDX_MODH1  8'h23
`define DCMT_IDX_MODL1  8'h24
`define DCMT_IDX_CH0C1  8'h25
`define DCMT_IDX_SC2    8'h2b
`define DCMT_IDX_CNTH2  8'h2c
`define DCMT_IDX_CNTL2  8'h2d
`define DCMT_IDX_MODH2  8'h2e
`define DCMT_IDX_MODL2  8'h2f
`define DCMT_IDX_CH0C2  8'h30
`define DCMT_IDX_SYS    8'h3f
// Status/control fields
`define DCMT_SC_OVF     7
`define DCMT_SC_OVIE    6
`define DCMT_SC_HALT    5
`define DCMT_SC_CLR     4
// Channel control fields
`define DCMT_CH_FLAG    7
// System control fields
`define DCMT_SYS_BCE    0
`define DCMT_SYS_WAIT   1
`define DCMT_SYS_STOP   2
`define DCMT_SYS_BRK    3
// Reset values and the largest valid divider code
`define DCMT_MOD_RST    16'hffff
`define DCMT_CH_RST     8'h00
`define DCMT_DIV_MAX    3'h6
`endif

//--- dcmt_pins.sv
// Purpose: Model of the channel datapath and pins beside the timer
// Assumes: Events are single-cycle pulses on the timer clock
// Notes:   Pins change every cycle so a stale sync never matches
`timescale 1ns/100ps
module dcmt_pins (
  input  wire logic       clk,
  input  wire logic [1:0] fire,
  output logic      [1:0] chanEvent,
  output logic      [3:0] chanPinIn
);
  initial begin
    chanEvent = 2'b00;
    chanPinIn = 4'h0;
  end
  // Events only when the bench asks; pins walk a pattern
  always @(posedge clk) begin
    chanEvent <= fire;
    chanPinIn <= chanPinIn + 4'h1;
  end
endmodule

//--- dcmt_regs.v
// Purpose: Register and control side of two 16-bit modulo timers
// Assumes: AHB-Lite single word transfers, one slave, always OKAY
// Notes:   Channel compare/capture datapath lies outside; event inputs
//          arrive from it on this clock, only the pins are synchronised
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
`include "dcmt_consts.vh"
module dcmt_regs #(
  parameter CNT_W = 16
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire [1:0]  chanEvent,
  input  wire [3:0]  chanPinIn,
  output reg  [3:0]  chanPinSync,
  output reg  [1:0]  wrapTick,
  output reg  [1:0]  cmpEnable,
  output reg         irqReq,
  output reg         wakeReq
);

////////////////////////////////////////////////////////////////////////
// Bus address phase capture
reg        wrPend_q;   // Write data phase pending
reg        rdPend_q;   // Read data phase pending
reg [7:0]  idx_q;      // Register index of pending transfer
wire       addrOk;     // Valid transfer this cycle
assign addrOk = hsel & htrans[1] & hready;

// Latch the address phase; the slave inserts one wait state for reads only
always @(posedge clk) begin
  if (rst) begin
    wrPend_q <= 1'b0;
    rdPend_q <= 1'b0;
    idx_q    <= 8'h00;
  end else begin
    wrPend_q <= addrOk & hwrite;
    rdPend_q <= addrOk & ~hwrite;
    if (addrOk) begin
      idx_q <= haddr[9:2];
    end
  end
end

////////////////////////////////////////////////////////////////////////
// System control: break clear, wait, stop, break state
reg [3:0] sys_q;       // Break-clear, wait, stop, break
wire      brk;         // Debug break active
wire      stopMode;    // Stop mode active
wire      clrOk;       // Flags may be cleared now
assign brk      = sys_q[`DCMT_SYS_BRK];
assign stopMode = sys_q[`DCMT_SYS_STOP];
assign clrOk    = ~brk | sys_q[`DCMT_SYS_BCE];

// Write strobe for the data phase
wire wrSys;
assign wrSys = wrPend_q & (idx_q == `DCMT_IDX_SYS);

always @(posedge clk) begin
  if (rst) begin
    sys_q <= 4'h0;
  end else if (wrSys) begin
    sys_q <= hwdata[3:0];
  end
end

////////////////////////////////////////////////////////////////////////
// Pin synchronisers: two flops, the first read only by the second
reg [3:0] pinMeta_q;
always @(posedge clk) begin
  if (rst) begin
    pinMeta_q   <= 4'h0;
    chanPinSync <= 4'h0;
  end else begin
    pinMeta_q   <= chanPinIn;
    chanPinSync <= pinMeta_q;
  end
end

////////////////////////////////////////////////////////////////////////
// Index decode used by every timer instance
function isIdx;
  input [7:0] cur;
  input [7:0] want;
  begin
    isIdx = (cur == want);
  end
endfunction

wire [7:0] idxSc   [0:1];
wire [7:0] idxCnth [0:1];
wire [7:0] idxCntl [0:1];
wire [7:0] idxModh [0:1];
wire [7:0] idxModl [0:1];
wire [7:0] idxCh   [0:1];
assign idxSc[0]   = `DCMT_IDX_SC1;
assign idxSc[1]   = `DCMT_IDX_SC2;
assign idxCnth[0] = `DCMT_IDX_CNTH1;
assign idxCnth[1] = `DCMT_IDX_CNTH2;
assign idxCntl[0] = `DCMT_IDX_CNTL1;
assign idxCntl[1] = `DCMT_IDX_CNTL2;
assign idxModh[0] = `DCMT_IDX_MODH1;
assign idxModh[1] = `DCMT_IDX_MODH2;
assign idxModl[0] = `DCMT_IDX_MODL1;
assign idxModl[1] = `DCMT_IDX_MODL2;
assign idxCh[0]   = `DCMT_IDX_CH0C1;
assign idxCh[1]   = `DCMT_IDX_CH0C2;

wire [7:0] rdVal [0:1]; // Read value of each timer, zero if not hit
wire [1:0] irqT;        // Interrupt request of each timer

////////////////////////////////////////////////////////////////////////
// Two identical timer instances
genvar t;
generate
  for (t = 0; t < 2; t = t + 1) begin : gTim
    reg [CNT_W-1:0] cnt_q;     // Counter
    reg [5:0]       pre_q;     // Prescaler
    reg [15:0]      mod_q;     // Period
    reg             modLock_q; // Period high written, low pending
    reg             ovf_q;     // Overflow flag
    reg             ovfArm_q;  // Flag read while set
    reg             ovie_q;    // Overflow interrupt enable
    reg             halt_q;    // Counter halt
    reg [2:0]       div_q;     // Clock divider select
    reg [7:0]       lowBuf_q;  // Latched low count byte
    reg             lowLat_q;  // Low byte latch held
    reg [7:0]       ch_q;      // Channel 0 control
    reg             chArm_q;   // Channel flag read while set
    wire wrSc, rdSc, wrModh, wrModl, rdCnth, rdCntl, wrCh, rdCh;
    wire run, tick, match, clrCnt;
    assign wrSc   = wrPend_q & isIdx(idx_q, idxSc[t]);
    assign rdSc   = rdPend_q & isIdx(idx_q, idxSc[t]);
    assign wrModh = wrPend_q & isIdx(idx_q, idxModh[t]);
    assign wrModl = wrPend_q & isIdx(idx_q, idxModl[t]);
    assign rdCnth = rdPend_q & isIdx(idx_q, idxCnth[t]);
    assign rdCntl = rdPend_q & isIdx(idx_q, idxCntl[t]);
    assign wrCh   = wrPend_q & isIdx(idx_q, idxCh[t]);
    assign rdCh   = rdPend_q & isIdx(idx_q, idxCh[t]);
    // Wait keeps running; stop, break and halt freeze the count
    assign run    = ~halt_q & ~stopMode & ~brk;
    // Divider tick: low bits of the prescaler all ones
    assign tick   = run & ((pre_q & ((6'h01 << div_q) - 6'h01)) ==
                    ((6'h01 << div_q) - 6'h01));
    assign match  = tick & (cnt_q == mod_q);
    assign clrCnt = wrSc & hwdata[`DCMT_SC_CLR];

    // Counter and prescaler
    always @(posedge clk) begin
      if (rst) begin
        cnt_q <= {CNT_W{1'b0}};
        pre_q <= 6'h00;
      end else if (clrCnt) begin
        cnt_q <= {CNT_W{1'b0}};
        pre_q <= 6'h00;
      end else if (run) begin
        pre_q <= pre_q + 6'h01;
        if (match) begin
          cnt_q <= {CNT_W{1'b0}};
        end else if (tick) begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end

    // Status/control: halt, enable, divider, overflow flag
    always @(posedge clk) begin
      if (rst) begin
        halt_q   <= 1'b1;
        ovie_q   <= 1'b0;
        div_q    <= 3'h0;
        ovf_q    <= 1'b0;
        ovfArm_q <= 1'b0;
      end else begin
        if (wrSc) begin
          halt_q <= hwdata[`DCMT_SC_HALT];
          ovie_q <= hwdata[`DCMT_SC_OVIE];
          // Code 7 is not a valid divider; keep the old one
          if (hwdata[2:0] <= `DCMT_DIV_MAX) begin
            div_q <= hwdata[2:0];
          end
        end
        if (match & ~modLock_q) begin
          ovf_q    <= 1'b1;
          ovfArm_q <= 1'b0;
        end else if (wrSc & ~hwdata[`DCMT_SC_OVF] & ovfArm_q & clrOk) begin
          ovf_q    <= 1'b0;
          ovfArm_q <= 1'b0;
        end else if (rdSc & ovf_q & clrOk) begin
          ovfArm_q <= 1'b1;
        end
      end
    end

    // Period registers
    always @(posedge clk) begin
      if (rst) begin
        mod_q     <= `DCMT_MOD_RST;
        modLock_q <= 1'b0;
      end else if (wrModh) begin
        mod_q[15:8] <= hwdata[7:0];
        modLock_q   <= 1'b1;
      end else if (wrModl) begin
        mod_q[7:0]  <= hwdata[7:0];
        modLock_q   <= 1'b0;
      end
    end

    // Low count byte latch, kept across a break
    always @(posedge clk) begin
      if (rst) begin
        lowBuf_q <= 8'h00;
        lowLat_q <= 1'b0;
      end else if (rdCnth & ~lowLat_q) begin
        lowBuf_q <= cnt_q[7:0];
        lowLat_q <= 1'b1;
      end else if (rdCntl) begin
        lowLat_q <= 1'b0;
      end
    end

    // Channel control register and its event flag
    always @(posedge clk) begin
      if (rst) begin
        ch_q    <= `DCMT_CH_RST;
        chArm_q <= 1'b0;
      end else begin
        if (wrCh) begin
          ch_q[6:0] <= hwdata[6:0];
        end
        if (chanEvent[t]) begin
          ch_q[`DCMT_CH_FLAG] <= 1'b1;
          chArm_q <= 1'b0;
        end else if (wrCh & ~hwdata[`DCMT_CH_FLAG] & chArm_q & clrOk) begin
          ch_q[`DCMT_CH_FLAG] <= 1'b0;
          chArm_q <= 1'b0;
        end else if (rdCh & ch_q[`DCMT_CH_FLAG] & clrOk) begin
          chArm_q <= 1'b1;
        end
      end
    end

    // Wrap and compare gating toward the channel datapath
    always @(posedge clk) begin
      if (rst) begin
        wrapTick[t]  <= 1'b0;
        cmpEnable[t] <= 1'b0;
      end else begin
        wrapTick[t]  <= match;
        // Toggle-on-wrap: overflow wins over a same-cycle compare
        cmpEnable[t] <= ~(match & ch_q[1]);
      end
    end

    assign irqT[t] = (ovf_q & ovie_q) | (ch_q[7] & ch_q[6]);
    assign rdVal[t] =
      rdSc   ? {ovf_q, ovie_q, halt_q, 2'b00, div_q} :
      rdCnth ? cnt_q[15:8] :
      rdCntl ? (lowLat_q ? lowBuf_q : cnt_q[7:0]) :
      (rdPend_q & isIdx(idx_q, idxModh[t])) ? mod_q[15:8] :
      (rdPend_q & isIdx(idx_q, idxModl[t])) ? mod_q[7:0] :
      rdCh   ? ch_q : 8'h00;
  end
endgenerate

////////////////////////////////////////////////////////////////////////
// Read data and interrupt outputs, all registered
wire        wrSysRd;   // Pending index hits the system control word
wire [31:0] rdNext;    // Read data for the next cycle
assign wrSysRd = (idx_q == `DCMT_IDX_SYS);
assign rdNext = {24'h000000, rdVal[0] | rdVal[1] |
                ((rdPend_q & wrSysRd) ? {4'h0, sys_q} : 8'h00)};

// Read data is presented one cycle after the data phase begins; the
// master samples it at the hready edge that closes the data phase, so
// the data phase is extended by one wait state for reads
always @(posedge clk) begin
  if (rst) begin
    hrdata    <= 32'h00000000;
    hreadyout <= 1'b1;
    hresp     <= 1'b0;
    irqReq    <= 1'b0;
    wakeReq   <= 1'b0;
  end else begin
    hresp   <= 1'b0;
    hrdata  <= rdNext;
    irqReq  <= |irqT;
    wakeReq <= (|irqT) & sys_q[`DCMT_SYS_WAIT];
    hreadyout <= ~(addrOk & ~hwrite);
  end
end

endmodule

//--- dcmt_regs_chk.sv
// Purpose: Port-level assertions for the dual modulo timer registers
// Assumes: One clock, synchronous active-high reset
// Notes:   Sees only the ports of dcmt_regs; attached by bind below
`timescale 1ns/100ps
module dcmt_regs_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [1:0]  chanEvent,
  input wire logic [3:0]  chanPinIn,
  input wire logic [3:0]  chanPinSync,
  input wire logic [1:0]  wrapTick,
  input wire logic [1:0]  cmpEnable,
  input wire logic        irqReq,
  input wire logic        wakeReq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Request taken on this edge
  wire take = hsel && htrans[1] && hready;
  ////////////////////////////////////////////////////////////////////////
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  // Reset itself is the antecedent, so no disable here
  a_reset_quiet: assert property (disable iff (1'b0)
    rst |=> !irqReq && !wakeReq && wrapTick == 2'b00)
    else $error("outputs not quiet after reset");
  a_idle_after_rst: assert property (
    $fell(rst) |-> wrapTick == 2'b00 [*3])
    else $error("counter ran while halted by reset");
  a_wake_irq: assert property (wakeReq |-> irqReq)
    else $error("wake without interrupt");
  a_sync_delay: assert property (!$past(rst) && !$past(rst, 2)
    |-> chanPinSync == $past(chanPinIn, 2))
    else $error("pin synchroniser delay wrong");
  a_data_upper: assert property (hreadyout |-> hrdata[31:8] == 24'h0)
    else $error("upper read data not zero");
endmodule
bind dcmt_regs dcmt_regs_chk i_dcmt_regs_chk (.clk, .rst, .hsel, .haddr,
  .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
  .chanEvent, .chanPinIn, .chanPinSync, .wrapTick, .cmpEnable, .irqReq,
  .wakeReq);

//--- testbench.sv
// Purpose: Self-checking bench for the timer register block
// Assumes: AHB-Lite single word transfers, byte addr is index times 4
// Notes:   Each scenario is one task that judges its own results
`timescale 1ns/100ps
`include "dcmt_consts.vh"
module testbench;
  logic        clk, rst, hsel, hwrite, hreadyout, hresp, irqReq, wakeReq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, chanEvent, wrapTick, cmpEnable, fire;
  logic [2:0]  hsize;
  logic [3:0]  chanPinIn, chanPinSync;
  logic [7:0]  rv;
  int          numErrors = 0;
  int          comparisons = 0;
  dcmt_regs #(.CNT_W(16)) i_dcmt_regs (.clk, .rst, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .chanEvent, .chanPinIn, .chanPinSync, .wrapTick,
    .cmpEnable, .irqReq, .wakeReq);
  dcmt_pins i_dcmt_pins (.clk, .fire, .chanEvent, .chanPinIn);
  ////////////////////////////////////////////////////////////////////////
  task summarize;
    $display("errors %0d comparisons %0d", numErrors, comparisons);
    if (numErrors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      numErrors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bounded wait for hready sampled high at a rising edge
  task wt;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      numErrors++;
      summarize;
    end
  endtask
  task xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    wt;
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    wt;
    rv = hrdata[7:0];
  endtask
  task rc(input logic [7:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    chk(rv, exp);
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask
  // Bounded wait for a wrap pulse (sel 0) or a wake request (sel 1)
  task waitFor(input int sel);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((sel == 0 ? wrapTick[0] : wakeReq) !== 1'b1 && n < 100);
    if (n >= 100) begin
      numErrors++;
      $display("MISMATCH t=%0t wait ran out", $time);
      summarize;
    end
  endtask
  // Two low-byte reads must agree while the counter is frozen
  task frozen;
    logic [7:0] v;
    xfer(1'b0, `DCMT_IDX_CNTL1, 8'h00);
    v = rv;
    repeat (8) @(posedge clk);
    rc(`DCMT_IDX_CNTL1, v);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task sResets;
    logic [7:0] b;
    for (int t = 0; t < 2; t++) begin
      b = t ? `DCMT_IDX_SC2 : `DCMT_IDX_SC1;
      rc(b, 8'h20);
      rc(b + 8'h3, 8'hff);
      rc(b + 8'h4, 8'hff);
      rc(b + 8'h5, 8'h00);
      rc(b + 8'h1, 8'h00);
    end
    rc(8'h10, 8'h00);
  endtask
  task sOverflow;
    xfer(1'b1, `DCMT_IDX_SC1, 8'h30);
    xfer(1'b1, `DCMT_IDX_MODH1, 8'h00);
    xfer(1'b1, `DCMT_IDX_MODL1, 8'h03);
    rc(`DCMT_IDX_MODL1, 8'h03);
    xfer(1'b1, `DCMT_IDX_SC1, 8'h40);
    waitFor(0);
    // Zero write before any read must not clear the flag
    xfer(1'b1, `DCMT_IDX_SC1, 8'h60);
    rc(`DCMT_IDX_SC1, 8'he0);
    chk({7'h0, irqReq}, 8'h01);
    xfer(1'b1, `DCMT_IDX_SC1, 8'h60);
    rc(`DCMT_IDX_SC1, 8'h60);
    chk({7'h0, irqReq}, 8'h00);
  endtask
  task sClear;
    xfer(1'b1, `DCMT_IDX_SC1, 8'h30);
    rc(`DCMT_IDX_CNTH1, 8'h00);
    rc(`DCMT_IDX_CNTL1, 8'h00);
    rc(`DCMT_IDX_SC1, 8'h20);
    xfer(1'b1, `DCMT_IDX_SC1, 8'h25);
    xfer(1'b1, `DCMT_IDX_SC1, 8'h27);
    rc(`DCMT_IDX_SC1, 8'h25);
  endtask
  task sChan;
    @(posedge clk);
    fire <= 2'b01;
    @(posedge clk);
    fire <= 2'b00;
    rc(`DCMT_IDX_CH0C1, 8'h80);
    xfer(1'b1, `DCMT_IDX_CH0C1, 8'h00);
    rc(`DCMT_IDX_CH0C1, 8'h00);
  endtask
  task sBreak;
    logic [7:0] v;
    wr(`DCMT_IDX_SC1, 8'h30);
    wr(`DCMT_IDX_MODH1, 8'h00);
    wr(`DCMT_IDX_SC1, 8'h00);
    repeat (20) @(posedge clk);
    rc(`DCMT_IDX_SC1, 8'h00);
    wr(`DCMT_IDX_MODL1, 8'h03);
    repeat (2) @(posedge clk);
    waitFor(0);
    rc(`DCMT_IDX_SC1, 8'h80);
    wr(`DCMT_IDX_SC1, 8'h00);
    rc(`DCMT_IDX_SC1, 8'h80);
    wr(`DCMT_IDX_SC1, 8'ha0);
    rc(`DCMT_IDX_SC1, 8'ha0);
    xfer(1'b0, `DCMT_IDX_CNTL1, 8'h00);
    v = rv;
    wr(`DCMT_IDX_SYS, 8'h08);
    wr(`DCMT_IDX_SC1, 8'h20);
    rc(`DCMT_IDX_SC1, 8'ha0);
    rc(`DCMT_IDX_CNTH1, 8'h00);
    wr(`DCMT_IDX_SYS, 8'h00);
    wr(`DCMT_IDX_SC1, 8'h20);
    rc(`DCMT_IDX_SC1, 8'h20);
    rc(`DCMT_IDX_CNTL1, v);
    wr(`DCMT_IDX_SC1, 8'h00);
    waitFor(0);
    wr(`DCMT_IDX_SC1, 8'ha0);
    wr(`DCMT_IDX_SYS, 8'h09);
    rc(`DCMT_IDX_SC1, 8'ha0);
    wr(`DCMT_IDX_SC1, 8'h20);
    wr(`DCMT_IDX_SYS, 8'h00);
    rc(`DCMT_IDX_SC1, 8'h20);
    wr(`DCMT_IDX_SC1, 8'h10);
    wr(`DCMT_IDX_SYS, 8'h08);
    frozen;
    wr(`DCMT_IDX_SYS, 8'h04);
    frozen;
    wr(`DCMT_IDX_SYS, 8'h00);
    wr(`DCMT_IDX_SC1, 8'h40);
    wr(`DCMT_IDX_SYS, 8'h02);
    waitFor(1);
    wr(`DCMT_IDX_SYS, 8'h00);
    wr(`DCMT_IDX_CH0C1, 8'h02);
    waitFor(0);
    chk({7'h0, cmpEnable[0]}, 8'h00);
    wr(`DCMT_IDX_SC1, 8'he0);
    rc(`DCMT_IDX_SC1, 8'he0);
    wr(`DCMT_IDX_SC1, 8'h60);
    rc(`DCMT_IDX_SC1, 8'h60);
    chk({7'h0, wakeReq}, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    {hsel, hwrite, haddr, htrans, hwdata, fire} = '0;
    hsize = 3'b010;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    sResets;
    sOverflow;
    sClear;
    sChan;
    sBreak;
    summarize;
  end
endmodule
